/* hw/spi_flash_regs.svh */
// timing counts, opcode defaults and field positions for the serial flash sequencer
`ifndef SPI_FLASH_REGS_SVH
`define SPI_FLASH_REGS_SVH

`define CLK_FREQ_MHZ         40
`define CLK_FREQ_KHZ         40000

// self-timed sector erase duration, ms
`define BLOCK_WIPE_TIME_MS   1000
`define BLOCK_WIPE_CYCLES    (`BLOCK_WIPE_TIME_MS * `CLK_FREQ_KHZ)
// write inhibit after power-on reset, ms (inside the 1 to 10 ms band)
`define POWERUP_WRITE_MS     10
`define POWERUP_WRITE_CYCLES (`POWERUP_WRITE_MS * `CLK_FREQ_KHZ)
// deep sleep entry and wake delays, ns; least times, rounded up
`define SLEEP_ENTRY_DELAY_NS 3000
`define SLEEP_ENTRY_CYCLES   ((`SLEEP_ENTRY_DELAY_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define WAKE_DELAY_NS        3000
`define WAKE_CYCLES          ((`WAKE_DELAY_NS * `CLK_FREQ_MHZ + 999) / 1000)

// opcode defaults, values arbitrary
`define OP_WRITE_UNLOCK      8'hA1
`define OP_BLOCK_WIPE        8'hA2
`define OP_DEEP_SLEEP        8'hA3
`define OP_WAKE              8'hA4

// frame bit counts
`define BITS_OPCODE          6'h08
`define BITS_WIPE            6'h20
`define BIT_CNT_MAX          6'h21

// address fields
`define SECTOR_MSB           18
`define SECTOR_LSB           16
`define OPCODE_MSB           31
`define OPCODE_LSB           24

`endif

/* hw/spi_flash_pkg.sv */
// types shared by the serial flash sequencer
package spi_flash_pkg;

  typedef enum logic [3:0] {
    ST_STANDBY  = 4'b0001,
    ST_ENTERING = 4'b0010,
    ST_SLEEP    = 4'b0100,
    ST_WAKING   = 4'b1000
  } power_state_t;

  typedef logic [2:0] sector_t;

endpackage

/* hw/pin_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds the second stage only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end

endmodule

/* hw/delay_timer.sv */
// down counter that times one self-timed interval
`timescale 1ns/1ps
module delay_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] load_i,
  output logic                  run_o,
  output logic                  done_o
);

  logic [WIDTH-1:0] count;

  // done marks the last cycle of the interval
  assign done_o = run_o && (count == {{(WIDTH-1){1'b0}}, 1'b1});

  // a start while running restarts; callers never do that
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      run_o <= 1'b0;
    end else if (start_i) begin
      count <= load_i;
      run_o <= 1'b1;
    end else if (run_o) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      run_o <= !done_o;
    end
  end

endmodule

/* hw/spi_flash_erase_sleep_powerup.sv */
// sector erase, deep sleep and power-up write inhibit sequencer of a serial flash
// Function
// - sector erase runs only when the write latch was set by write unlock
// - erase fills the whole addressed sector with ones; any address inside selects it
// - erase executes only when select rises right after bit 32
// - valid erase starts a timed cycle; busy is one during it, zero after
// - write latch is cleared before the erase cycle ends
// - erase of a sector holding a protected page is not executed
// - while busy, erase, deep sleep and wake are rejected without side effect
// - the five top address bits are ignored
// - in deep sleep every command except wake is ignored
// - raising select with no cycle running gives standby, not deep sleep
// - deep sleep ends at power loss; power-up always lands in standby
// - deep sleep is the opcode alone, executed when select rises after bit 8
// - after a valid deep sleep command, wait the entry delay, then sleep
// - wake is the opcode alone; extra clocks before select rises reject it
// - after wake, standby follows the wake delay; master keeps select high meanwhile
// - power-on reset holds all logic in reset, no command answered
// - write unlock and erase type commands are ignored during the power-up delay
// - at power-up the device is in standby with the write latch clear
// - serial data is sampled on each serial clock rising edge while selected
`timescale 1ns/1ps
`include "spi_flash_regs.svh"
module spi_flash_erase_sleep_powerup #(
  parameter logic [7:0]  OP_WRITE_UNLOCK = `OP_WRITE_UNLOCK,
  parameter logic [7:0]  OP_BLOCK_WIPE   = `OP_BLOCK_WIPE,
  parameter logic [7:0]  OP_DEEP_SLEEP   = `OP_DEEP_SLEEP,
  parameter logic [7:0]  OP_WAKE         = `OP_WAKE,
  parameter logic [31:0] WIPE_CYCLES     = `BLOCK_WIPE_CYCLES,
  parameter logic [31:0] POWERUP_CYCLES  = `POWERUP_WRITE_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 sclk_i,
  input  wire logic                 sdi_i,
  input  wire logic                 ext_busy_i,
  input  wire logic [7:0]           sector_protect_i,
  output logic                      busy_o,
  output logic                      write_latch_o,
  output logic                      erase_active_o,
  output spi_flash_pkg::sector_t    erase_sector_o,
  output logic                      deep_sleep_o,
  output logic                      standby_o,
  output logic                      write_inhibit_o,
  output logic                      cmd_reject_o
);
  import spi_flash_pkg::*;

  localparam int          SLEEP_CYC = `SLEEP_ENTRY_CYCLES;
  localparam int          WAKE_CYC  = `WAKE_CYCLES;
  localparam logic [31:0] SLEEP_LD  = 32'(SLEEP_CYC);
  localparam logic [31:0] WAKE_LD   = 32'(WAKE_CYC);

  power_state_t state;
  logic         cs_n_s;
  logic         sclk_s;
  logic         sdi_s;
  logic         cs_n_d;
  logic         sclk_d;
  logic         cs_rise;
  logic         sclk_rise;
  logic [31:0]  shreg;
  logic [5:0]   bit_cnt;
  logic         por_start;
  logic         pu_run;
  logic         wipe_run;
  logic         wipe_done;
  logic         sleep_done;
  logic         wake_done;
  logic         inhibit;
  logic         busy_any;
  logic [7:0]   op8;
  logic [7:0]   op32;
  sector_t      sector;
  logic         do_unlock;
  logic         do_wipe;
  logic         do_sleep;
  logic         do_wake;
  logic         rejected;

  // pins come from the master's domain; cs idles high
  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'b100)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .pin_i    ({cs_n_i, sclk_i, sdi_i}),
    .sync_o   ({cs_n_s, sclk_s, sdi_s})
  );

  // edge finders run on the synchronised copies only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  assign cs_rise   = cs_n_s && !cs_n_d;
  assign sclk_rise = sclk_s && !sclk_d && !cs_n_s;

  // shift in on each serial clock rise; counter saturates so long frames stay invalid
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shreg   <= 32'h0000_0000;
      bit_cnt <= 6'h00;
    end else if (cs_n_s && !cs_rise) begin
      bit_cnt <= 6'h00;
    end else if (sclk_rise) begin
      shreg <= {shreg[30:0], sdi_s};
      if (bit_cnt != `BIT_CNT_MAX) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // power-up inhibit timer starts on the first cycle after reset release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_start <= 1'b1;
    end else begin
      por_start <= 1'b0;
    end
  end

  delay_timer #(.WIDTH(32)) u_pu_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (por_start),
    .load_i   (POWERUP_CYCLES),
    .run_o    (pu_run),
    .done_o   ()
  );

  assign inhibit  = por_start || pu_run;
  assign busy_any = wipe_run || ext_busy_i;

  // decode at the select rise; the opcode is the first byte of the frame
  assign op8    = shreg[7:0];
  assign op32   = shreg[`OPCODE_MSB:`OPCODE_LSB];
  assign sector = shreg[`SECTOR_MSB:`SECTOR_LSB];

  // only a standby device takes unlock, erase or sleep; a sleeping one only wake
  always_comb begin
    do_unlock = 1'b0;
    do_wipe   = 1'b0;
    do_sleep  = 1'b0;
    do_wake   = 1'b0;
    rejected  = 1'b0;
    if (cs_rise) begin
      if (state == ST_STANDBY) begin
        if (bit_cnt == `BITS_OPCODE && op8 == OP_WRITE_UNLOCK) begin
          do_unlock = !busy_any && !inhibit;
        end
        if (bit_cnt == `BITS_WIPE && op32 == OP_BLOCK_WIPE) begin
          do_wipe  = write_latch_o && !busy_any && !inhibit && !sector_protect_i[sector];
          rejected = busy_any;
        end
        if (bit_cnt == `BITS_OPCODE && op8 == OP_DEEP_SLEEP) begin
          do_sleep = !busy_any;
          rejected = busy_any;
        end
      end else if (state == ST_SLEEP) begin
        if (bit_cnt == `BITS_OPCODE && op8 == OP_WAKE) begin
          do_wake  = !busy_any;
          rejected = busy_any;
        end
      end
    end
  end

  delay_timer #(.WIDTH(32)) u_wipe_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (do_wipe),
    .load_i   (WIPE_CYCLES),
    .run_o    (wipe_run),
    .done_o   (wipe_done)
  );

  delay_timer #(.WIDTH(32)) u_sleep_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (do_sleep),
    .load_i   (SLEEP_LD),
    .run_o    (),
    .done_o   (sleep_done)
  );

  delay_timer #(.WIDTH(32)) u_wake_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (do_wake),
    .load_i   (WAKE_LD),
    .run_o    (),
    .done_o   (wake_done)
  );

  // power mode; reset always lands in standby, never deep sleep
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_STANDBY;
    end else begin
      case (state)
        ST_STANDBY: begin
          if (do_sleep) begin
            state <= ST_ENTERING;
          end
        end
        ST_ENTERING: begin
          if (sleep_done) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (do_wake) begin
            state <= ST_WAKING;
          end
        end
        ST_WAKING: begin
          if (wake_done) begin
            state <= ST_STANDBY;
          end
        end
        default: begin
          state <= ST_STANDBY;
        end
      endcase
    end
  end

  // write latch: cleared as the erase starts, well before it ends
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_latch_o <= 1'b0;
    end else if (do_unlock) begin
      write_latch_o <= 1'b1;
    end else if (do_wipe) begin
      write_latch_o <= 1'b0;
    end
  end

  // erase request to the array: whole sector driven to ones while active
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_active_o <= 1'b0;
      erase_sector_o <= 3'h0;
    end else if (do_wipe) begin
      erase_active_o <= 1'b1;
      erase_sector_o <= sector;
    end else if (wipe_done) begin
      erase_active_o <= 1'b0;
    end
  end

  // status outputs; busy also covers cycles run by the page logic
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o          <= 1'b0;
      deep_sleep_o    <= 1'b0;
      standby_o       <= 1'b0;
      write_inhibit_o <= 1'b1;
      cmd_reject_o    <= 1'b0;
    end else begin
      busy_o          <= busy_any || do_wipe;
      deep_sleep_o    <= (state == ST_SLEEP);
      standby_o       <= cs_n_s && !busy_any && (state == ST_STANDBY);
      write_inhibit_o <= inhibit;
      cmd_reject_o    <= rejected;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  localparam int SLEEP_LO = SLEEP_CYC - 1;
  localparam int SLEEP_HI = SLEEP_CYC + 2;
  localparam int WAKE_LO  = WAKE_CYC - 1;
  localparam int WAKE_HI  = WAKE_CYC + 2;

  a_wipe_latch: assert property ($rose(erase_active_o) |-> $past(write_latch_o))
    else $error("erase started without write latch");
  a_wipe_frame: assert property ($rose(erase_active_o) |-> $past(bit_cnt) == `BITS_WIPE && $past(op32) == OP_BLOCK_WIPE)
    else $error("erase started on a bad frame");
  a_latch_drop: assert property ($rose(erase_active_o) |-> !write_latch_o ##1 busy_o)
    else $error("write latch not cleared at erase start");
  a_wipe_protect: assert property ($rose(erase_active_o) |-> !sector_protect_i[erase_sector_o])
    else $error("erase on protected sector");
  a_busy_hold: assert property ($rose(erase_active_o) |=> busy_o [*4])
    else $error("busy dropped during erase");
  a_busy_reject: assert property (wipe_run && cs_rise && state == ST_STANDBY |=> state == ST_STANDBY && $stable(erase_sector_o))
    else $error("command disturbed running erase");
  a_sector_pick: assert property ($rose(erase_active_o) |-> erase_sector_o == $past(shreg[`SECTOR_MSB:`SECTOR_LSB]))
    else $error("wrong sector selected");
  a_sleep_deaf: assert property (state == ST_SLEEP |=> !$rose(write_latch_o) && !$rose(erase_active_o))
    else $error("command acted in deep sleep");
  a_sleep_entry: assert property ($rose(state == ST_ENTERING) |-> ##[SLEEP_LO:SLEEP_HI] state == ST_SLEEP)
    else $error("deep sleep entry delay wrong");
  a_wake_exit: assert property ($rose(state == ST_WAKING) |-> ##[WAKE_LO:WAKE_HI] state == ST_STANDBY)
    else $error("wake delay wrong");
  a_wake_extra: assert property (cs_rise && state == ST_SLEEP && bit_cnt != `BITS_OPCODE |=> state == ST_SLEEP)
    else $error("wake with extra clocks accepted");
  a_pu_inhibit: assert property (write_inhibit_o |-> !$rose(write_latch_o))
    else $error("write latch set during power-up delay");

  c_erase_run: cover property ($rose(erase_active_o) ##[1:1000] $fell(erase_active_o));
  c_sleep_wake: cover property (state == ST_SLEEP ##[1:1000] state == ST_WAKING ##[1:300] state == ST_STANDBY);
  c_busy_reject: cover property (cmd_reject_o);

endmodule

/* tb/spi_master_model.sv */
// serial bus master model that drives command frames into the flash sequencer
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic clk_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  localparam int HALF_SCLK = 4; // 100 ns half period of the 200 ns link clock

  // idle bus: deselected, link clock parked low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  // one frame, msb first; the link clock stands still outside frames
  task automatic send(input logic [39:0] bits, input int n);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_o <= bits[39-i];
      repeat (HALF_SCLK) @(posedge clk_i);
      sclk_o <= 1'b1; // data stable around the rising link edge
      repeat (HALF_SCLK) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF_SCLK) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // released line shows the opposite level so a stale bit cannot pass for data
    sdi_o <= ~sdi_o;
    repeat (2 * HALF_SCLK) @(posedge clk_i);
  endtask
endmodule

/* tb/spi_flash_erase_sleep_powerup_tb_top.sv */
// self-checking bench for the sector erase, deep sleep and power-up sequencer
`timescale 1ns/1ps
`include "spi_flash_regs.svh"
module spi_flash_erase_sleep_powerup_tb_top;
  import spi_flash_pkg::*;
  localparam logic [31:0] WIPE_N       = 32'h0000_00C8; // 200 cycles, shortened erase
  localparam logic [31:0] POWERUP_N    = 32'h0000_0640; // 1600 cycles, shortened inhibit
  localparam int          SELECT_DELAY = 1200;          // 30 us at 25 ns
  localparam logic [39:0] UNLOCK       = {`OP_WRITE_UNLOCK, 32'h0000_0000};
  localparam logic [39:0] SLEEP        = {`OP_DEEP_SLEEP, 32'h0000_0000};
  localparam logic [39:0] WAKE         = {`OP_WAKE, 32'h0000_0000};

  logic      clk_i;
  logic      resetn_i;
  logic      cs_n_i;
  logic      sclk_i;
  logic      sdi_i;
  logic      ext_busy_i;
  logic [7:0] sector_protect_i;
  logic      busy_o;
  logic      write_latch_o;
  logic      erase_active_o;
  sector_t   erase_sector_o;
  logic      deep_sleep_o;
  logic      standby_o;
  logic      write_inhibit_o;
  logic      cmd_reject_o;
  int        fails;
  int        total_checks;
  int        rejects = 0;
  int        rejects0;

  spi_flash_erase_sleep_powerup #(
    .WIPE_CYCLES    (WIPE_N),
    .POWERUP_CYCLES (POWERUP_N)
  ) spi_flash_erase_sleep_powerup_inst (
    .clk_i            (clk_i),
    .resetn_i         (resetn_i),
    .cs_n_i           (cs_n_i),
    .sclk_i           (sclk_i),
    .sdi_i            (sdi_i),
    .ext_busy_i       (ext_busy_i),
    .sector_protect_i (sector_protect_i),
    .busy_o           (busy_o),
    .write_latch_o    (write_latch_o),
    .erase_active_o   (erase_active_o),
    .erase_sector_o   (erase_sector_o),
    .deep_sleep_o     (deep_sleep_o),
    .standby_o        (standby_o),
    .write_inhibit_o  (write_inhibit_o),
    .cmd_reject_o     (cmd_reject_o)
  );

  spi_master_model spi_master_model_inst (
    .clk_i  (clk_i),
    .cs_n_o (cs_n_i),
    .sclk_o (sclk_i),
    .sdi_o  (sdi_i)
  );

  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // count one-cycle reject pulses so none is missed between checks
  always @(posedge clk_i) begin
    if (cmd_reject_o === 1'b1) rejects <= rejects + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return deep_sleep_o;
      1: return standby_o;
      2: return busy_o;
      default: return write_inhibit_o;
    endcase
  endfunction

  // bounded wait sampled on falling edges, away from design updates
  task automatic wait_for(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    while (pick(sel) !== val && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (pick(sel) !== val) begin
      fails++;
      $display("wrong value at %0t ns: wait ran out on signal %0d", $time, sel);
      final_report();
    end
  endtask

  task automatic frame(input logic [39:0] bits, input int n);
    spi_master_model_inst.send(bits, n);
    @(negedge clk_i);
  endtask

  function automatic logic [39:0] wipe(input logic [23:0] a);
    return {`OP_BLOCK_WIPE, a, 8'h00};
  endfunction

  initial begin
    resetn_i = 1'b0;
    ext_busy_i = 1'b0;
    sector_protect_i = 8'h20; // sector 5 holds a protected page
    fails = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    check(write_inhibit_o, 1'b1, "inhibit in reset");
    check(write_latch_o, 1'b0, "latch in reset");
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (SELECT_DELAY) @(posedge clk_i);
    frame(UNLOCK, 8);
    check(write_inhibit_o, 1'b1, "inhibit window");
    check(write_latch_o, 1'b0, "unlock in inhibit");
    check(deep_sleep_o, 1'b0, "sleep at power-up");
    wait_for(3, 1'b0, 2000);
    check(standby_o, 1'b1, "standby at power-up");
    frame(wipe(24'h0E_0000), 32);
    check(erase_active_o, 1'b0, "erase without unlock");
    frame(UNLOCK, 8);
    check(write_latch_o, 1'b1, "unlock");
    frame(wipe(24'hFE_ABCD), 31);
    check(erase_active_o, 1'b0, "short erase frame");
    frame(wipe(24'hFE_ABCD), 33);
    check(erase_active_o, 1'b0, "long erase frame");
    frame(wipe(24'hFD_0000), 32);
    check(erase_active_o, 1'b0, "protected sector");
    check(write_latch_o, 1'b1, "latch kept");
    frame(wipe(24'hFE_ABCD), 32);
    check(erase_active_o, 1'b1, "erase start");
    check(busy_o, 1'b1, "busy in erase");
    check(erase_sector_o, 3'h6, "sector");
    check(standby_o, 1'b0, "standby in erase");
    rejects0 = rejects;
    frame(SLEEP, 8);
    check(rejects - rejects0, 1, "sleep reject");
    check(erase_active_o, 1'b1, "erase undisturbed");
    wait_for(2, 1'b0, 400);
    check(erase_active_o, 1'b0, "erase end");
    check(write_latch_o, 1'b0, "latch after erase");
    check(deep_sleep_o, 1'b0, "sleep during erase");
    wait_for(1, 1'b1, 10);
    frame(SLEEP, 9);
    check(standby_o, 1'b1, "nine bit sleep");
    frame(SLEEP, 8);
    check(deep_sleep_o, 1'b0, "sleep entry delay");
    wait_for(0, 1'b1, 300);
    frame(UNLOCK, 8);
    check(write_latch_o, 1'b0, "unlock in sleep");
    frame(WAKE, 9);
    check(deep_sleep_o, 1'b1, "nine bit wake");
    frame(WAKE, 8);
    check(deep_sleep_o, 1'b0, "wake");
    check(standby_o, 1'b0, "wake delay");
    wait_for(1, 1'b1, 300); // select stays high meanwhile
    frame(UNLOCK, 8);
    check(write_latch_o, 1'b1, "unlock after wake");
    @(posedge clk_i);
    ext_busy_i <= 1'b1;
    rejects0 = rejects;
    frame(wipe(24'h06_0000), 32);
    check(rejects - rejects0, 1, "erase reject");
    check(erase_active_o, 1'b0, "erase while busy");
    check(write_latch_o, 1'b1, "latch kept while busy");
    rejects0 = rejects;
    frame(SLEEP, 8);
    check(busy_o, 1'b1, "outside busy");
    check(rejects - rejects0, 1, "sleep reject");
    repeat (200) @(negedge clk_i);
    check(deep_sleep_o, 1'b0, "sleep while busy");
    @(posedge clk_i);
    ext_busy_i <= 1'b0;
    frame(SLEEP, 8);
    wait_for(0, 1'b1, 300);
    @(posedge clk_i);
    ext_busy_i <= 1'b1;
    rejects0 = rejects;
    frame(WAKE, 8);
    check(rejects - rejects0, 1, "wake reject");
    check(deep_sleep_o, 1'b1, "sleep kept while busy");
    @(posedge clk_i);
    ext_busy_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    check(deep_sleep_o, 1'b0, "sleep in reset");
    @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_for(3, 1'b0, 2000);
    check(standby_o, 1'b1, "standby after reset");
    check(write_latch_o, 1'b0, "latch after reset");
    final_report();
  end
endmodule
